// file: hdl/otpmc_regs.svh
// Offsets, field positions, reset values and timing counts of the OTP mode control block
`ifndef OTPMC_REGS_SVH
`define OTPMC_REGS_SVH
`define OTPMC_MODE_ADDR 32'h40008000
`define OTPMC_PMUX_HI 29
`define OTPMC_PMUX_LO 28
`define OTPMC_FAST_BIT 8
`define OTPMC_PSEL_BIT 7
`define OTPMC_TWOCC_BIT 6
`define OTPMC_FLUSH_BIT 5
`define OTPMC_DMA_BIT 4
`define OTPMC_MODE_HI 2
`define OTPMC_MODE_LO 0
`define OTPMC_MODE_RESET 32'h00000000
`define OTPMC_WMASK 32'h300001f7
`define OTPMC_CLK_PERIOD_NS 10
`define OTPMC_FAST_READ_CYC 1
`define OTPMC_SLOW_READ_CYC 2
`endif

// file: hdl/otpmc_pkg.sv
// Types of the OTP mode control block
package otpmc_pkg;
	// Operating mode codes; upper three codes are reserved test modes
	typedef enum logic [2:0] {
		OTPMC_STANDBY = 3'h0,
		OTPMC_MANUAL_READ = 3'h1,
		OTPMC_MANUAL_PROGRAM = 3'h2,
		OTPMC_AUTO_READ = 3'h3,
		OTPMC_AUTO_PROGRAM = 3'h4
	} otpmc_mode_t;

	// Decoded controls sent to the sequencer and macrocells
	typedef struct packed {
		logic [2:0] mode;
		logic fast_program_timing;
		logic program_from_port;
		logic two_cycle_read_access;
		logic dma_active;
		logic fifo_source;
		logic read_strobe;
	} otpmc_ctrl_t;

	// Analog settings routed to the programming port
	typedef struct packed {
		logic [15:0] bandgap_setting;
		logic [15:0] rssi_compensation_setting;
		logic [7:0] rf_io_setting;
		logic [11:0] lna_setting_first;
		logic [11:0] lna_setting_second;
		logic [4:0] lna_setting_third;
		logic [3:0] vco_setting;
	} otpmc_settings_t;
endpackage

// file: hdl/otpmc_buf2.sv
// Two-entry valid/ready buffer for the programming data path
`timescale 1ns/1ns
module otpmc_buf2 (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [31:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [31:0] out_data_o
);
	logic [31:0] mem [0:1]; // Storage entries
	logic wr_ptr; // Write index
	logic rd_ptr; // Read index
	logic [1:0] count; // Occupancy
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;

	assign in_ready_o = (count != 2'h2);
	assign out_valid_o = (count != 2'h0);
	assign out_data_o = mem[rd_ptr];

	////////////////////////////////////////////////////////////////////////
	// Pointer and count update; flush discards everything at once
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else if (flush_i) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push) wr_ptr <= ~wr_ptr;
			if (pop) rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	// Data entries need no reset; valid gates them
	always_ff @(posedge clk_i) begin
		if (push) mem[wr_ptr] <= in_data_i;
	end

	// A third word would overwrite the oldest one still waiting
	property p_no_overflow;
		@(posedge clk_i) disable iff (rst_i) count <= 2'h2;
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("buffer count above two");
endmodule

// file: hdl/otpmc_top.sv
// OTP controller mode control register and data source selection
//
// Summary of operation
// - Mode codes 000 to 100, 101-111 reserved
// - Bit 8 selects fast programming timing
// - Port-select clear takes FIFO data, word count
// - Port-select set programs one port word only
// - Bit 6 selects two-cycle macrocell reads
// - Writing bit 5 flushes FIFO, self clears
// - DMA off means software uses FIFO port
// - DMA on moves data automatically
// - Serial interface writes force DMA bit zero
// - DMA idle in port-source automatic program
// - Field 29:28 routes programming port value
`timescale 1ns/1ns
`include "otpmc_regs.svh"
module otpmc_top import otpmc_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bus_wr_i, // System bus write strobe
	input wire logic bus_rd_i, // System bus read strobe
	input wire logic [31:0] bus_addr_i,
	input wire logic [31:0] bus_wdata_i,
	output logic [31:0] bus_rdata_o,
	input wire logic ser_wr_i, // Serial programming interface write strobe
	input wire logic [31:0] ser_wdata_i,
	input wire otpmc_settings_t settings_i,
	input wire logic fifo_valid_i, // FIFO data from software port or DMA
	output logic fifo_ready_o,
	input wire logic [31:0] fifo_data_i,
	input wire logic [12:0] word_count_setting_i,
	output logic prog_valid_o, // Word offered to the programming sequencer
	input wire logic prog_ready_i,
	output logic [31:0] prog_data_o,
	output logic [12:0] prog_words_o,
	output otpmc_ctrl_t ctrl_o,
	output logic fifo_flush_o
);
	logic [31:0] mode_reg; // Stored control register
	logic flush_pulse; // One-cycle flush
	logic read_phase; // Toggles for two-cycle reads
	logic port_word_done; // Single port word already taken
	logic [31:0] rdata; // Registered read data
	logic [31:0] port_value; // Registered programming port value
	logic [31:0] next_port_value;

	////////////////////////////////////////////////////////////////////////
	// Decode
	wire bus_hit = (bus_addr_i == `OTPMC_MODE_ADDR);
	wire bus_write = bus_wr_i && bus_hit;
	wire [2:0] operating_mode_field = mode_reg[`OTPMC_MODE_HI:`OTPMC_MODE_LO];
	wire [1:0] program_port_source_select = mode_reg[`OTPMC_PMUX_HI:`OTPMC_PMUX_LO];
	wire fast_program_timing = mode_reg[`OTPMC_FAST_BIT];
	wire program_from_port_select = mode_reg[`OTPMC_PSEL_BIT];
	wire two_cycle_read_access = mode_reg[`OTPMC_TWOCC_BIT];
	wire dma_transfer_enable = mode_reg[`OTPMC_DMA_BIT];
	wire is_auto_prog = (operating_mode_field == OTPMC_AUTO_PROGRAM);
	wire is_auto_read = (operating_mode_field == OTPMC_AUTO_READ);
	wire port_source = is_auto_prog && program_from_port_select;
	wire fifo_source = is_auto_prog && !program_from_port_select;
	// DMA only in automatic modes and never for a port word
	wire dma_active = dma_transfer_enable && (is_auto_read || fifo_source);
	// Serial writes drop the DMA bit; the flush bit is never stored
	wire [31:0] ser_value = ser_wdata_i & `OTPMC_WMASK & ~(32'h1 << `OTPMC_DMA_BIT);
	wire [31:0] bus_value = bus_wdata_i & `OTPMC_WMASK;
	wire [31:0] next_mode_reg = bus_write ? bus_value : ser_value;
	wire wr_any = bus_write || ser_wr_i;
	wire flush_req = wr_any && next_mode_reg[`OTPMC_FLUSH_BIT];

	////////////////////////////////////////////////////////////////////////
	// Control register; bus write wins when both write together
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_reg <= `OTPMC_MODE_RESET;
		end else if (wr_any) begin
			mode_reg <= next_mode_reg & ~(32'h1 << `OTPMC_FLUSH_BIT);
		end
	end

	// Flush pulse lasts one cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) flush_pulse <= 1'b0;
		else flush_pulse <= flush_req;
	end
	assign fifo_flush_o = flush_pulse;

	// Read data register; unmapped addresses read zero
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) rdata <= 32'h0;
		else if (bus_rd_i) rdata <= bus_hit ? mode_reg : 32'h0;
	end
	assign bus_rdata_o = rdata;

	////////////////////////////////////////////////////////////////////////
	// Read rate: strobe every cycle or every second cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) read_phase <= 1'b0;
		else if (two_cycle_read_access) read_phase <= ~read_phase;
		else read_phase <= 1'b0;
	end
	wire read_strobe = two_cycle_read_access ? read_phase : 1'b1;

	// Programming port mux
	always_comb begin
		case (program_port_source_select)
			2'h0: next_port_value = {16'h0, settings_i.bandgap_setting};
			2'h1: next_port_value = {settings_i.rssi_compensation_setting, 8'h0,
				settings_i.rf_io_setting};
			2'h2: next_port_value = {3'h0, settings_i.lna_setting_third,
				settings_i.lna_setting_second, settings_i.lna_setting_first};
			2'h3: next_port_value = {28'h0, settings_i.vco_setting};
			default: next_port_value = 32'h0;
		endcase
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) port_value <= 32'h0;
		else port_value <= next_port_value;
	end

	////////////////////////////////////////////////////////////////////////
	// FIFO source path through the two-entry buffer
	logic buf_valid;
	logic [31:0] buf_data;
	otpmc_buf2 u_buf (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.flush_i(flush_pulse),
		.in_valid_i(fifo_valid_i),
		.in_ready_o(fifo_ready_o),
		.in_data_i(fifo_data_i),
		.out_valid_o(buf_valid),
		.out_ready_i(prog_ready_i && fifo_source),
		.out_data_o(buf_data)
	);

	// One port word per entry into automatic program
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) port_word_done <= 1'b0;
		else if (!port_source) port_word_done <= 1'b0;
		else if (prog_valid_o && prog_ready_i) port_word_done <= 1'b1;
	end

	assign prog_valid_o = port_source ? !port_word_done : (fifo_source && buf_valid);
	assign prog_data_o = port_source ? port_value : buf_data;
	assign prog_words_o = port_source ? 13'h1 : word_count_setting_i;

	// Timing choice and mode go straight to the sequencer
	assign ctrl_o = '{mode: operating_mode_field,
		fast_program_timing: fast_program_timing,
		program_from_port: port_source,
		two_cycle_read_access: two_cycle_read_access,
		dma_active: dma_active,
		fifo_source: fifo_source,
		read_strobe: read_strobe};

	////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_flush_one;
		@(posedge clk_i) disable iff (rst_i) flush_req |=> fifo_flush_o ##1 !mode_reg[5];
	endproperty
	a_flush_one: assert property (p_flush_one) else $error("flush not one pulse");
	property p_ser_no_dma;
		@(posedge clk_i) disable iff (rst_i) (ser_wr_i && !bus_write) |=> !mode_reg[4];
	endproperty
	a_ser_no_dma: assert property (p_ser_no_dma) else $error("serial write kept DMA");
	property p_port_no_dma;
		@(posedge clk_i) disable iff (rst_i) port_source |-> !ctrl_o.dma_active;
	endproperty
	a_port_no_dma: assert property (p_port_no_dma) else $error("DMA active for port");
	property p_port_once;
		@(posedge clk_i) disable iff (rst_i)
			(port_source && prog_valid_o && prog_ready_i) ##1 port_source |-> !prog_valid_o;
	endproperty
	a_port_once: assert property (p_port_once) else $error("second port word");
	property p_two_cycle;
		@(posedge clk_i) disable iff (rst_i)
			(two_cycle_read_access && read_strobe) ##1 two_cycle_read_access |-> !read_strobe;
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("read too fast");
	property p_one_cycle;
		@(posedge clk_i) disable iff (rst_i) !two_cycle_read_access |-> read_strobe;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("read strobe missed");
	property p_fast;
		@(posedge clk_i) disable iff (rst_i)
			bus_write |=> ctrl_o.fast_program_timing == $past(bus_wdata_i[`OTPMC_FAST_BIT]);
	endproperty
	a_fast: assert property (p_fast) else $error("timing select wrong");
	property p_vco;
		@(posedge clk_i) disable iff (rst_i)
			(program_port_source_select == 2'h3) ##1 (program_port_source_select == 2'h3)
			|-> port_value[31:4] == 28'h0;
	endproperty
	a_vco: assert property (p_vco) else $error("port mux wrong");
	property p_fifo_words;
		@(posedge clk_i) disable iff (rst_i) fifo_source |-> prog_words_o == word_count_setting_i;
	endproperty
	a_fifo_words: assert property (p_fifo_words) else $error("word count wrong");
	// Reserved test codes must not start any automatic data movement
	property p_test_idle;
		@(posedge clk_i) disable iff (rst_i) (operating_mode_field > 3'h4)
			|-> !prog_valid_o && !ctrl_o.dma_active && !ctrl_o.fifo_source;
	endproperty
	a_test_idle: assert property (p_test_idle) else $error("test mode moved data");
	// Without the DMA bit software owns every transfer
	property p_no_dma;
		@(posedge clk_i) disable iff (rst_i) !dma_transfer_enable |-> !ctrl_o.dma_active;
	endproperty
	a_no_dma: assert property (p_no_dma) else $error("DMA active while off");
	// DMA follows the bit in automatic read
	property p_dma_read;
		@(posedge clk_i) disable iff (rst_i)
			(is_auto_read && dma_transfer_enable) |-> ctrl_o.dma_active;
	endproperty
	a_dma_read: assert property (p_dma_read) else $error("DMA idle in auto read");
	// Flush must not linger past its single cycle
	property p_flush_end;
		@(posedge clk_i) disable iff (rst_i) !flush_req |=> !fifo_flush_o;
	endproperty
	a_flush_end: assert property (p_flush_end) else $error("flush pulse too long");
	// Leaving reset finds standby and no pending flush
	property p_reset_defaults;
		@(posedge clk_i) $fell(rst_i) |-> (mode_reg == `OTPMC_MODE_RESET) && !fifo_flush_o;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("reset state wrong");
	c_auto_prog_port: cover property (@(posedge clk_i) port_source && prog_valid_o && prog_ready_i);
	c_fifo_word: cover property (@(posedge clk_i) fifo_source && prog_valid_o && prog_ready_i);
	c_flush: cover property (@(posedge clk_i) fifo_flush_o);
	c_dma: cover property (@(posedge clk_i) ctrl_o.dma_active);
	c_read_dma: cover property (@(posedge clk_i) is_auto_read && ctrl_o.dma_active);
endmodule

// file: verification/otpmc_sink.sv
// Model of the programming sequencer that takes words from the block
`timescale 1ns/1ns
module otpmc_sink (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic stall_i, // Bench-commanded slow acceptance
	input wire logic valid_i,
	output logic ready_o,
	input wire logic [31:0] data_i,
	output logic [31:0] last_o, // Most recent word taken
	output logic [15:0] count_o // Words taken since reset
);
	////////////////////////////////////////////////////////////////
	// Ready drops while stalled so back-pressure reaches the buffer
	assign ready_o = !stall_i;
	// Take one word on every handshake edge
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_o <= 16'h0000;
			last_o <= 32'h00000000;
		end else if (valid_i && ready_o) begin
			count_o <= count_o + 16'h0001;
			last_o <= data_i;
		end
	end
endmodule

// file: verification/testbench.sv
// Self-checking bench of the OTP mode control block
`timescale 1ns/1ns
`include "otpmc_regs.svh"
module testbench import otpmc_pkg::*;;
	logic clk, rst, bwr, brd, swr, fv, fr, pv, pr, flush, stall;
	logic [31:0] addr, wd, sd, fd, rdata, pdata, v, last;
	logic [12:0] wc, pw;
	logic [15:0] cnt, base;
	otpmc_settings_t set;
	otpmc_ctrl_t ctrl;
	int checks = 0;
	int num_errors = 0;
	otpmc_top otpmc_top_i (.clk_i(clk), .rst_i(rst), .bus_wr_i(bwr), .bus_rd_i(brd),
		.bus_addr_i(addr), .bus_wdata_i(wd), .bus_rdata_o(rdata), .ser_wr_i(swr),
		.ser_wdata_i(sd), .settings_i(set), .fifo_valid_i(fv), .fifo_ready_o(fr),
		.fifo_data_i(fd), .word_count_setting_i(wc), .prog_valid_o(pv), .prog_ready_i(pr),
		.prog_data_o(pdata), .prog_words_o(pw), .ctrl_o(ctrl), .fifo_flush_o(flush));
	otpmc_sink otpmc_sink_i (.clk_i(clk), .rst_i(rst), .stall_i(stall), .valid_i(pv),
		.ready_o(pr), .data_i(pdata), .last_o(last), .count_o(cnt));
	////////////////////////////////////////////////////////////////
	// Clock at 100 MHz
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Bus cycles: strobe held one clock, launched at the falling edge
	task automatic wr(input logic [31:0] d);
		@(negedge clk);
		bwr = 1;
		addr = `OTPMC_MODE_ADDR;
		wd = d;
		@(negedge clk);
		bwr = 0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(negedge clk);
		brd = 1;
		addr = a;
		@(negedge clk);
		brd = 0;
		v = rdata;
	endtask
	// One push; valid and data hold until the edge that sees ready high
	task automatic push(input logic [31:0] d);
		int i;
		@(negedge clk);
		fv = 1;
		fd = d;
		for (i = 0; i < 50 && fr !== 1'b1; i++) @(negedge clk);
		if (i == 50) begin
			num_errors++;
			final_report();
		end
		@(negedge clk);
		fv = 0;
	endtask
	// Bounded wait for the sink to reach a word count
	task automatic wait_cnt(input logic [15:0] n);
		int i;
		for (i = 0; i < 50 && cnt != n; i++) @(negedge clk);
		if (i == 50) begin
			num_errors++;
			final_report();
		end
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(`OTPMC_MODE_ADDR);
		check(v, `OTPMC_MODE_RESET);
		check(32'(ctrl), 32'h001);
		check(32'(pw), 32'h5);
	endtask
	task automatic t_modes();
		for (int m = 1; m < 5; m++) begin
			wr(32'(m));
			check(32'(ctrl.mode), 32'(m));
			wr(32'h0);
			check(32'(ctrl.mode), 32'h0);
		end
	endtask
	task automatic t_fields();
		wr(32'hffffffff);
		rd(`OTPMC_MODE_ADDR);
		check(v, 32'h300001d7);
		check({ctrl.fast_program_timing, ctrl.two_cycle_read_access}, 32'h3);
		v = {31'h0, ctrl.read_strobe};
		@(negedge clk);
		check(32'(ctrl.read_strobe), ~v & 32'h1);
		wr(32'h0);
		rd(32'h40008004);
		check(v, 32'h0);
		@(negedge clk);
		swr = 1;
		sd = 32'h13;
		@(negedge clk);
		swr = 0;
		rd(`OTPMC_MODE_ADDR);
		check(v, 32'h3);
		check(32'(ctrl.dma_active), 32'h0);
		wr(32'h13);
		check(32'(ctrl.dma_active), 32'h1);
		wr(32'h0);
	endtask
	task automatic t_port();
		stall = 1;
		for (int m = 0; m < 4; m++) begin
			base = cnt;
			wr({2'h0, 2'(m), 28'h94});
			repeat (2) @(negedge clk);
			case (m)
				0: v = {16'h0, set.bandgap_setting};
				1: v = {set.rssi_compensation_setting, 8'h0, set.rf_io_setting};
				2: v = {3'h0, set.lna_setting_third, set.lna_setting_second, set.lna_setting_first};
				default: v = {28'h0, set.vco_setting};
			endcase
			check(pdata, v);
			check({pv, pw}, 32'h2001);
			check(32'(ctrl.dma_active), 32'h0);
			check(32'(ctrl.program_from_port), 32'h1);
			stall = 0;
			repeat (4) @(negedge clk);
			check({pv, cnt}, 32'(base) + 32'h1);
			stall = 1;
			wr(32'h0);
		end
	endtask
	task automatic t_fifo();
		wr(32'h4);
		check({ctrl.dma_active, ctrl.fifo_source, pw}, 32'h2005);
		base = cnt;
		// Third word meets a full buffer and is never offered
		for (int i = 0; i < 3; i++) begin
			check(32'(fr), (i < 2) ? 32'h1 : 32'h0);
			if (i < 2) push(32'ha0 + 32'(i));
		end
		stall = 0;
		wait_cnt(base + 16'h2);
		check(last, 32'ha1);
		stall = 1;
		wr(32'h14);
		check(32'(ctrl.dma_active), 32'h1);
		push(32'hb0);
		push(32'hb1);
		check(32'(fr), 32'h0);
		wr(32'h34);
		// Flush pulse is out now; the buffer empties at the next edge
		check({flush, pv}, 32'h3);
		@(negedge clk);
		check({flush, fr, pv}, 32'h2);
		rd(`OTPMC_MODE_ADDR);
		check(v, 32'h14);
		stall = 0;
		repeat (3) @(negedge clk);
		check(32'(cnt), 32'(base) + 32'h2);
		wr(32'h0);
	endtask
	// Reset in mid-run over a busy setup must bring back every default
	task automatic t_rerst();
		wr(32'h300001d7);
		@(negedge clk);
		rst = 1;
		repeat (2) @(negedge clk);
		rst = 0;
		check(32'(ctrl), 32'h001);
		check({flush, pv, pw}, 32'h5);
		rd(`OTPMC_MODE_ADDR);
		check(v, `OTPMC_MODE_RESET);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1;
		{bwr, brd, swr, fv, stall} = 5'h0;
		{addr, wd, sd, fd} = 128'h0;
		wc = 13'h0005;
		set = {16'h1234, 16'habcd, 8'h5a, 12'h123, 12'h456, 5'h15, 4'h9};
		repeat (8) @(negedge clk);
		rst = 0;
		t_reset();
		t_modes();
		t_fields();
		t_port();
		t_fifo();
		t_rerst();
		final_report();
	end
endmodule
